//--- inc/scsi_irq_pkg.sv
// constants and types for the interrupt summary, bus id and timing registers
package scsi_irq_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
  localparam logic [7:0] IDX_IRQ_SUMMARY = 8'h0A;
  localparam logic [7:0] IDX_OWN_ID = 8'h0B;
  localparam logic [7:0] IDX_TARGET_ID = 8'h0C;
  localparam logic [7:0] IDX_TIMING = 8'h0D;
  localparam logic [31:0] ADDR_IRQ_MASK = {22'h000000, IDX_IRQ_MASK, 2'h0};
  localparam logic [31:0] ADDR_IRQ_SUMMARY = {22'h000000, IDX_IRQ_SUMMARY, 2'h0};
  localparam logic [31:0] ADDR_OWN_ID = {22'h000000, IDX_OWN_ID, 2'h0};
  localparam logic [31:0] ADDR_TARGET_ID = {22'h000000, IDX_TARGET_ID, 2'h0};
  localparam logic [31:0] ADDR_TIMING = {22'h000000, IDX_TIMING, 2'h0};

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic RST_DONE = 1'b1;

  // summary and mask bit positions
  localparam int BIT_ERROR = 2;
  localparam int BIT_EXCEPTION = 1;
  localparam int BIT_DONE = 0;

  // ack period: base clocks plus clocks per step of the period code
  localparam logic [5:0] ACK_BASE_CLKS = 6'h04;
  localparam logic [5:0] ACK_STEP_CLKS = 6'h02;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FAST_PERIOD_NS = 100;
  localparam logic [5:0] FAST_PERIOD_CLKS = 6'((FAST_PERIOD_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [5:0] ONE_CLK = 6'h01;

  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  // timing register layout
  typedef struct packed {
    logic [3:0] req_ack_offset_depth;
    logic [3:0] handshake_period_code;
  } transfer_timing_s;

  // software side interrupt enables
  typedef struct packed {
    logic error_irq_enable;
    logic exception_irq_enable;
    logic completion_irq_enable;
  } irq_enable_s;
endpackage

//--- rtl/scsi_irq_id_sync_regs.sv
// interrupt summary, bus id and req/ack timing registers behind an AHB-Lite slave
//
// Function
// - summary bit 2 is OR of error flags
// - error bit clears via error W1C or bit2
// - summary bit 1 is OR of exception flags
// - exception bit clears via exception W1C or bit1
// - bit 0 sets when last command finishes
// - new command clears completion flag
// - write one to bit 0 clears completion
// - completion flag set after reset, masked
// - one interrupt from three summary flags
// - mask bits 2,1,0 gate summary flags
// - own id at 0x0B used for arbitration
// - respond to own id on (re)selection
// - target id at 0x0C addresses selected device
// - timing bits 7-4 hold offset depth 1-15
// - zero offset means asynchronous transfers
// - nonzero offset: period sets ack pulses
// - ack period is 4 + 2*code clocks
// - fast mode code zero gives 100 ns
// - async: wait code clocks before sampling req
// - ignore req code clocks after trailing edge
//
// Added by the designer: the AHB-Lite slave port.
module scsi_irq_id_sync_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] error_status,
  input wire logic [7:0] exception_status,
  output logic error_clear_all,
  output logic exception_clear_all,
  input wire logic command_written,
  input wire logic command_finished,
  output logic irq,
  output logic [7:0] own_bus_id,
  output logic [7:0] target_bus_id,
  input wire logic [7:0] selection_id,
  output logic selection_match,
  input wire logic fast_sync,
  input wire logic sync_xfer_active,
  output logic sync_mode,
  output logic [3:0] req_ack_offset_depth,
  output logic ack_pulse,
  input wire logic ack_negated,
  input wire logic req_in,
  output logic req_valid
);

  logic addr_phase;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic wr_strobe;
  logic [31:0] rd_next;
  scsi_irq_pkg::irq_enable_s mask_reg;
  scsi_irq_pkg::transfer_timing_s timing_reg;
  logic command_finished_flag;
  logic summary_error;
  logic summary_exception;
  logic [7:0] summary_value;
  logic [7:0] own_id_reg;
  logic [7:0] target_id_reg;
  logic [5:0] ack_period;
  logic [5:0] ack_cnt_reg;
  logic [5:0] settle_clks;
  logic [5:0] ack_wait_reg;
  logic [5:0] req_mask_reg;
  logic req_prev_reg;

  // block overview, for whoever picks this up next
  //
  // register bus side
  // - single AHB-Lite slave, zero wait states, always OKAY
  // - byte address is four times the register index
  // - only the low byte of each word is meaningful
  // - upper read bits always zero, upper write bits dropped
  // - reads decoded in the address phase, hrdata is a flop
  // - writes land at the end of the data phase
  // - a read in the data phase of a write to the same
  //   register sees the old value; masters should idle between
  // - unmapped addresses read zero and ignore writes
  //
  // summary register
  // - error and exception bits mirror the outside registers
  // - they hold no state here, so they fall only when the
  //   outside register is cleared
  // - a one written to either bit only emits a clear pulse
  // - the completion bit is the only flag stored here
  // - completion set wins over both of its clears
  // - reads of bits 7-3 return zero
  //
  // interrupt
  // - registered, so it trails its causes by one clock
  // - mask is all zero after reset, so the completion flag
  //   that reset sets cannot raise an interrupt
  //
  // bus ids
  // - plain byte registers, exported to arbitration and
  //   selection logic outside this block
  // - selection match is registered, one clock behind the id
  //
  // timing register
  // - upper nibble: offset depth, zero selects async mode
  // - lower nibble: period code, shared by sync and async
  // - a new period code only shapes the next pulse or hold-off
  //
  // sync ack generation
  // - pulse period is base clocks plus step clocks per code
  // - fast mode with code zero uses a fixed clock count
  // - counter restarts whenever the transfer stops
  // - the first pulse follows the start by one clock
  //
  // async req qualification
  // - two hold-off counters, both loaded from the period code
  // - one starts when ack negates, one on each req trailing edge
  // - req_valid is low while either counter runs
  // - codes below two are the software's concern; hardware
  //   still uses them, and zero means no hold-off at all
  //
  // limitations
  // - req is taken as already synchronous to clk
  // - no wait states are ever inserted
  // - hsize is ignored: whole words only

  // the slave never stalls and never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase accepted when selected, active and the bus is ready
  assign addr_phase = hsel & htrans[scsi_irq_pkg::HTRANS_ACTIVE_BIT] & hready;
  assign wr_strobe = wr_pend_reg;

  // remember a write until its data phase supplies hwdata
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
    end
  end

  // summary flags follow the live status registers
  assign summary_error = |error_status;
  assign summary_exception = |exception_status;

  // upper bits stay zero
  always_comb begin
    summary_value = 8'h00;
    summary_value[scsi_irq_pkg::BIT_ERROR] = summary_error;
    summary_value[scsi_irq_pkg::BIT_EXCEPTION] = summary_exception;
    summary_value[scsi_irq_pkg::BIT_DONE] = command_finished_flag;
  end

  // read mux, decoded in the address phase so hrdata is a flop
  always_comb begin
    rd_next = 32'h00000000;
    if (haddr == scsi_irq_pkg::ADDR_IRQ_MASK) begin
      rd_next = {29'h00000000, mask_reg};
    end else if (haddr == scsi_irq_pkg::ADDR_IRQ_SUMMARY) begin
      rd_next = {24'h000000, summary_value};
    end else if (haddr == scsi_irq_pkg::ADDR_OWN_ID) begin
      rd_next = {24'h000000, own_id_reg};
    end else if (haddr == scsi_irq_pkg::ADDR_TARGET_ID) begin
      rd_next = {24'h000000, target_id_reg};
    end else if (haddr == scsi_irq_pkg::ADDR_TIMING) begin
      rd_next = {24'h000000, timing_reg};
    end
  end

  // unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= rd_next;
    end
  end

  // mask register, cleared by reset so nothing interrupts at first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= scsi_irq_pkg::RST_MASK;
    end else if (wr_strobe && wr_addr_reg == scsi_irq_pkg::ADDR_IRQ_MASK) begin
      mask_reg <= hwdata[2:0];
    end
  end

  // one-cycle clear requests to the error and exception registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_clear_all <= 1'b0;
      exception_clear_all <= 1'b0;
    end else begin
      error_clear_all <= wr_strobe && wr_addr_reg == scsi_irq_pkg::ADDR_IRQ_SUMMARY
        && hwdata[scsi_irq_pkg::BIT_ERROR];
      exception_clear_all <= wr_strobe && wr_addr_reg == scsi_irq_pkg::ADDR_IRQ_SUMMARY
        && hwdata[scsi_irq_pkg::BIT_EXCEPTION];
    end
  end

  // completion flag: set beats both clears so a finish is never lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      command_finished_flag <= scsi_irq_pkg::RST_DONE;
    end else if (command_finished) begin
      command_finished_flag <= 1'b1;
    end else if (command_written) begin
      command_finished_flag <= 1'b0;
    end else if (wr_strobe && wr_addr_reg == scsi_irq_pkg::ADDR_IRQ_SUMMARY
        && hwdata[scsi_irq_pkg::BIT_DONE]) begin
      command_finished_flag <= 1'b0;
    end
  end

  // single interrupt line, registered so it never glitches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (summary_error & mask_reg.error_irq_enable)
        | (summary_exception & mask_reg.exception_irq_enable)
        | (command_finished_flag & mask_reg.completion_irq_enable);
    end
  end

  // bus id registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      own_id_reg <= scsi_irq_pkg::RST_BYTE;
      target_id_reg <= scsi_irq_pkg::RST_BYTE;
    end else if (wr_strobe) begin
      if (wr_addr_reg == scsi_irq_pkg::ADDR_OWN_ID) begin
        own_id_reg <= hwdata[7:0];
      end else if (wr_addr_reg == scsi_irq_pkg::ADDR_TARGET_ID) begin
        target_id_reg <= hwdata[7:0];
      end
    end
  end

  assign own_bus_id = own_id_reg;
  assign target_bus_id = target_id_reg;

  // id seen on the bus during (re)selection compared with our own
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selection_match <= 1'b0;
    end else begin
      selection_match <= selection_id == own_id_reg;
    end
  end

  // timing register; a new period code takes effect at the next ack counter reload, not mid-period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timing_reg <= scsi_irq_pkg::RST_BYTE;
    end else if (wr_strobe && wr_addr_reg == scsi_irq_pkg::ADDR_TIMING) begin
      timing_reg <= hwdata[7:0];
    end
  end

  assign req_ack_offset_depth = timing_reg.req_ack_offset_depth;
  assign sync_mode = timing_reg.req_ack_offset_depth != 4'h0;

  // synchronous ack period in controller clocks
  always_comb begin
    if (fast_sync && timing_reg.handshake_period_code == 4'h0) begin
      ack_period = scsi_irq_pkg::FAST_PERIOD_CLKS;
    end else begin
      ack_period = scsi_irq_pkg::ACK_BASE_CLKS
        + 6'(scsi_irq_pkg::ACK_STEP_CLKS * {2'h0, timing_reg.handshake_period_code});
    end
  end

  // ack pulse generator, one pulse per period while a sync transfer runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_cnt_reg <= 6'h00;
      ack_pulse <= 1'b0;
    end else if (sync_mode && sync_xfer_active) begin
      ack_pulse <= ack_cnt_reg == 6'h00;
      if (ack_cnt_reg == 6'h00) begin
        ack_cnt_reg <= ack_period - scsi_irq_pkg::ONE_CLK;
      end else begin
        ack_cnt_reg <= ack_cnt_reg - scsi_irq_pkg::ONE_CLK;
      end
    end else begin
      ack_cnt_reg <= 6'h00;
      ack_pulse <= 1'b0;
    end
  end

  // settle time used for both async waits; a code of zero means none
  assign settle_clks = {2'h0, timing_reg.handshake_period_code};

  // async: hold off req sampling after ack negates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_wait_reg <= 6'h00;
    end else if (ack_negated && !sync_mode) begin
      ack_wait_reg <= settle_clks;
    end else if (ack_wait_reg != 6'h00) begin
      ack_wait_reg <= ack_wait_reg - scsi_irq_pkg::ONE_CLK;
    end
  end

  // blank req after each trailing edge so cable reflections are not seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_prev_reg <= 1'b0;
      req_mask_reg <= 6'h00;
    end else begin
      req_prev_reg <= req_in;
      if (req_prev_reg && !req_in) begin
        req_mask_reg <= settle_clks;
      end else if (req_mask_reg != 6'h00) begin
        req_mask_reg <= req_mask_reg - scsi_irq_pkg::ONE_CLK;
      end
    end
  end

  // qualified req, combinational handshake output
  assign req_valid = req_in && ack_wait_reg == 6'h00 && req_mask_reg == 6'h00;

endmodule

//--- dv/scsi_irq_id_sync_regs_asserts.sv
// port level checks for the interrupt summary, id and timing registers
module scsi_irq_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic error_clear_all,
  input wire logic exception_clear_all,
  input wire logic [7:0] own_bus_id,
  input wire logic [7:0] selection_id,
  input wire logic selection_match,
  input wire logic sync_mode,
  input wire logic [3:0] req_ack_offset_depth,
  input wire logic ack_pulse,
  input wire logic req_in,
  input wire logic req_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // address phase of a summary write, ending on its data phase
  sequence s_sum_wr;
    hsel && htrans[1] && hready && hwrite && haddr == scsi_irq_pkg::ADDR_IRQ_SUMMARY ##1 1'b1;
  endsequence
  a_err_clear: assert property (s_sum_wr ##0 hwdata[2] |=> error_clear_all)
    else $error("error clear pulse missing");
  a_err_cause: assert property (error_clear_all |-> $past(hwdata[2])
    && $past(hsel && htrans[1] && hwrite && haddr == scsi_irq_pkg::ADDR_IRQ_SUMMARY, 2))
    else $error("error clear pulse without a write");
  a_exc_clear: assert property (s_sum_wr ##0 hwdata[1] |=> exception_clear_all)
    else $error("exception clear pulse missing");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_rdata_high: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above the byte not zero");
  a_sync_map: assert property (sync_mode == (req_ack_offset_depth != 4'h0))
    else $error("sync mode disagrees with offset");
  a_ack_async: assert property (!$past(sync_mode) |-> !ack_pulse)
    else $error("ack pulse in asynchronous mode");
  // shortest period is four clocks, so three quiet cycles follow each pulse
  a_ack_gap: assert property (ack_pulse |=> !ack_pulse [*3])
    else $error("ack pulses too close");
  a_sel_match: assert property (!$past(rst) |->
    selection_match == ($past(selection_id) == $past(own_bus_id)))
    else $error("selection match wrong");
  a_req_gate: assert property (req_valid |-> req_in) else $error("req valid without req");
endmodule

bind scsi_irq_id_sync_regs scsi_irq_checker u_chk (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .error_clear_all(error_clear_all),
  .exception_clear_all(exception_clear_all), .own_bus_id(own_bus_id),
  .selection_id(selection_id), .selection_match(selection_match), .sync_mode(sync_mode),
  .req_ack_offset_depth(req_ack_offset_depth), .ack_pulse(ack_pulse), .req_in(req_in),
  .req_valid(req_valid));

//--- dv/scsi_target_model.sv
// far side bus device: drives req and the selection id
module scsi_target_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic drop,
  input wire logic [7:0] id_cfg,
  output logic req_in,
  output logic [7:0] selection_id
);
  timeunit 1ns;
  timeprecision 1ps;
  // req held asserted, one low cycle per drop request to make a trailing edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_in <= 1'b0;
      selection_id <= 8'h00;
    end else begin
      req_in <= !drop;
      selection_id <= id_cfg;
    end
  end
endmodule

//--- dv/scsi_irq_id_sync_regs_tb.sv
// self-checking bench for the interrupt summary, id and timing registers
module scsi_irq_id_sync_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, hsel, hwrite, hresp, hreadyout, irq, drop, fast_sync, sync_xfer_active;
  logic command_written, command_finished, ack_negated, ack_pulse, req_in, req_valid;
  logic error_clear_all, exception_clear_all, sync_mode, selection_match;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] error_status, exception_status, own_bus_id, target_bus_id, selection_id, id_cfg;
  logic [3:0] req_ack_offset_depth;
  wire logic hready;
  int err_count, num_checks, cyc, seed, m_done, n, k;
  int codes[$] = '{0, 1, 5, 15, 0};
  logic [31:0] ra[6] = '{scsi_irq_pkg::ADDR_IRQ_MASK, scsi_irq_pkg::ADDR_OWN_ID,
    scsi_irq_pkg::ADDR_TARGET_ID, scsi_irq_pkg::ADDR_TIMING, 32'h00000040,
    scsi_irq_pkg::ADDR_IRQ_SUMMARY};
  assign hready = hreadyout;
  scsi_irq_id_sync_regs DUT (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .error_status, .exception_status,
    .error_clear_all, .exception_clear_all, .command_written, .command_finished, .irq,
    .own_bus_id, .target_bus_id, .selection_id, .selection_match, .fast_sync,
    .sync_xfer_active, .sync_mode, .req_ack_offset_depth, .ack_pulse, .ack_negated,
    .req_in, .req_valid);
  scsi_target_model u_far (.clk, .rst, .drop, .id_cfg, .req_in, .selection_id);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // outside status registers clear on the pulse; a hang ends the run
  always @(posedge clk) begin
    if (error_clear_all === 1'b1) error_status <= 8'h00;
    if (exception_clear_all === 1'b1) exception_status <= 8'h00;
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // single AHB transfer; idles a cycle before each address phase
  task xfer(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rdchk(string nm, logic [31:0] a, logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(nm, rd, exp);
  endtask
  function automatic logic [31:0] sum_exp();
    return {29'h0, |error_status, |exception_status, m_done[0]};
  endfunction
  task count_low();
    k = 0;
    repeat (12) begin
      @(posedge clk);
      if (req_valid !== 1'b1) k++;
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {rst, hsel, hwrite, drop, fast_sync, sync_xfer_active} = 6'h21;
    {command_written, command_finished, ack_negated} = 3'h0;
    {haddr, hwdata, htrans, error_status, exception_status, id_cfg} = '0;
    seed = 60;
    m_done = 1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk("irq", irq, 0);
    rdchk("summary", ra[5], sum_exp());
    for (int i = 0; i < 5; i++) rdchk("reset value", ra[i], 0);
    // ids from random data, only the low byte is kept
    for (int i = 1; i < 3; i++) begin
      n = $random(seed);
      xfer(1'b1, ra[i], n);
      rdchk("bus id", ra[i], n & 8'hFF);
    end
    chk("target id", target_bus_id, n & 8'hFF);
    id_cfg <= own_bus_id;
    repeat (3) @(posedge clk);
    chk("match", selection_match, 1);
    id_cfg <= own_bus_id ^ 8'h01;
    repeat (3) @(posedge clk);
    chk("mismatch", selection_match, 0);
    error_status <= 8'h80 >> ($random(seed) & 7);
    exception_status <= 8'h01 << ($random(seed) & 5);
    // both status values are nonzero; expectations fixed by the rules
    rdchk("summary", ra[5], 32'h00000007);
    xfer(1'b1, ra[5], 32'h00000004);
    rdchk("summary", ra[5], 32'h00000003);
    xfer(1'b1, ra[5], 32'hFFFFFFFA);
    rdchk("summary", ra[5], 32'h00000001);
    xfer(1'b1, ra[0], 32'h00000007);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1);
    xfer(1'b1, ra[5], 32'h00000001);
    m_done = 0;
    rdchk("summary", ra[5], sum_exp());
    chk("irq", irq, 0);
    command_finished <= 1'b1;
    @(posedge clk);
    command_finished <= 1'b0;
    m_done = 1;
    repeat (2) @(posedge clk);
    chk("irq", irq, 1);
    command_written <= 1'b1;
    @(posedge clk);
    command_written <= 1'b0;
    m_done = 0;
    rdchk("summary", ra[5], sum_exp());
    error_status <= 8'h10;
    repeat (3) @(posedge clk);
    chk("irq", irq, 1);
    xfer(1'b1, ra[0], 32'h00000003);
    repeat (2) @(posedge clk);
    chk("irq", irq, 0);
    // ack period per code; transfer stopped first so the count restarts
    for (int i = 0; i < 5; i++) begin
      sync_xfer_active <= 1'b0;
      fast_sync <= (i == 4);
      repeat (4) @(posedge clk);
      xfer(1'b1, ra[3], ((15 - 3 * i) << 4) | codes[i]);
      @(posedge clk);
      chk("depth", req_ack_offset_depth, 15 - 3 * i);
      chk("sync", sync_mode, 1);
      sync_xfer_active <= 1'b1;
      do @(posedge clk); while (ack_pulse !== 1'b1);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (ack_pulse !== 1'b1);
      chk("period", n, (i == 4) ? 25 : 4 + 2 * codes[i]);
    end
    xfer(1'b1, ra[3], 32'h00000003);
    @(posedge clk);
    chk("sync", sync_mode, 0);
    ack_negated <= 1'b1;
    @(posedge clk);
    ack_negated <= 1'b0;
    count_low();
    chk("ack hold", k, 3);
    drop <= 1'b1;
    @(posedge clk);
    drop <= 1'b0;
    count_low();
    chk("req hold", k, 4);
    end_sim();
  end
endmodule
